// ### rtl/scs_pkg.sv
// Constants, field layout and state encodings for the supply control slave.
// Assumes a 50 MHz system clock and a separate sampling clock at the bus.
package scs_pkg;

  // System clock rate and protection timing.
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned T_OFF_MS    = 900;
  localparam int unsigned T_ON_DIV    = 10;
  localparam int unsigned T_OFF_CYC   = T_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned T_ON_CYC    = T_OFF_CYC / T_ON_DIV;
  localparam int unsigned TIMER_W     = 26;

  // Bit positions inside the supply control and status byte.
  localparam int unsigned BIT_PULSED_LIMIT = 7;
  localparam int unsigned BIT_TX_SEL       = 6;
  localparam int unsigned BIT_TONE_EN      = 5;
  localparam int unsigned BIT_LOSS_COMP    = 4;
  localparam int unsigned BIT_HV_SEL       = 3;
  localparam int unsigned BIT_POWER_EN     = 2;
  localparam int unsigned BIT_OTF          = 1;
  localparam int unsigned BIT_OLF          = 0;
  localparam int unsigned WR_BITS          = 6;

  // Value after reset and undervoltage lockout.
  localparam logic [7:0]         REG_RESET = 8'h00;
  localparam logic [WR_BITS-1:0] CTRL_RESET = 6'h00;

  // Bus framing.
  localparam logic [6:0] ADDR_BASE  = 7'h08;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam int unsigned FILT_LEN  = 3;

  // Bus engine states.
  typedef enum logic [6:0] {
    BUS_IDLE      = 7'h01,
    BUS_ADDR      = 7'h02,
    BUS_ADDR_ACK  = 7'h04,
    BUS_WRITE     = 7'h08,
    BUS_WRITE_ACK = 7'h10,
    BUS_READ      = 7'h20,
    BUS_READ_ACK  = 7'h40
  } scs_bus_state_t;

  // Pulsed overload protection states.
  typedef enum logic [2:0] {
    PROT_NORMAL = 3'h1,
    PROT_OFF    = 3'h2,
    PROT_RETRY  = 3'h4
  } scs_prot_state_t;

endpackage

// ### rtl/scs_sync.sv
// Two-flop level synchroniser, one lane per bit.
// Assumes each lane is a slowly changing level or a held toggle.
module scs_sync
  import scs_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  // Destination clock.
  input  wire logic             clk_in,
  // Asynchronous levels and their synchronised copies.
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // The first stage feeds only the second; nothing else may look at it.
  genvar g;
  for (g = 0; g < WIDTH; g++)
  begin : g_lane
    always_ff @(posedge clk_in)
    begin
      meta_reg[g] <= d_in[g];
      q_reg[g]    <= meta_reg[g];
    end
  end

  assign q_out = q_reg;

endmodule

// ### rtl/scs_top.sv
// Two-wire slave with one supply control and status byte, plus protection timing.
// Assumes open-drain resolution of SDA outside and slow, static strap and flag pins.
module scs_top
  import scs_pkg::*;
#(
  parameter int unsigned OFF_CYCLES = T_OFF_CYC,
  parameter int unsigned ON_CYCLES  = T_ON_CYC,
  parameter int unsigned FILT_SAMP  = FILT_LEN
)
(
  // System clock and reset.
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  // Bus sampling clock and bus lines.
  input  wire logic       link_clk_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out_out,
  output logic            sda_oe_out,
  // Straps and analog status.
  input  wire logic [1:0] addr_select_in,
  input  wire logic       uvlo_in,
  input  wire logic       overload_detect_in,
  input  wire logic       thermal_shutdown_in,
  input  wire logic       tone_data_in,
  // Power stage controls.
  output logic            power_stage_on_out,
  output logic            high_voltage_select_out,
  output logic            cable_loss_comp_out,
  output logic            tone_gate_out,
  output logic            rx_output_on_out,
  output logic            tx_output_on_out,
  output logic            static_clamp_out
);

  // Synchronised inputs in both domains.
  logic [5:0] m_sync;
  logic [6:0] l_sync;
  logic       uvlo_s;
  logic       ovl_s;
  logic       therm_s;
  logic       tone_s;
  logic       wr_tog_s;
  logic       snap_ack_s;
  logic       scl_s;
  logic       sda_s;
  logic       silence_s;
  logic       snap_req_s;
  logic [1:0] addr_sel_s;
  logic       rst_l_s;

  // System domain state.
  logic [WR_BITS-1:0] ctrl_reg;
  logic [WR_BITS-1:0] ctrl_next;
  logic               wr_seen_reg;
  logic               silence_reg;
  logic [7:0]         snap_reg;
  logic               snap_req_reg;
  logic               otf_reg;
  logic               olf_reg;
  logic               olf_next;
  scs_prot_state_t    prot_reg;
  scs_prot_state_t    prot_next;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] timer_next;
  logic               ov_seen_reg;
  logic               ov_seen_next;

  // Link domain state.
  logic               filt_reg [2];
  logic [1:0]         filt_cnt_reg [2];
  logic               scl_d_reg;
  logic               sda_d_reg;
  scs_bus_state_t     bus_reg;
  scs_bus_state_t     bus_next;
  logic [3:0]         cnt_reg;
  logic [3:0]         cnt_next;
  logic [7:0]         shift_reg;
  logic [7:0]         shift_next;
  logic [7:0]         tx_reg;
  logic [7:0]         tx_next;
  logic               oe_reg;
  logic               oe_next;
  logic               rw_reg;
  logic               rw_next;
  logic               ack_seen_reg;
  logic               ack_seen_next;
  logic               wr_tog_reg;
  logic               wr_tog_next;
  logic [WR_BITS-1:0] wr_data_reg;
  logic [WR_BITS-1:0] wr_data_next;
  logic [7:0]         rd_copy_reg;
  logic               snap_ack_reg;
  logic               sda_drv_reg;

  // Both domains see their asynchronous inputs only through two flops.
  scs_sync #(.WIDTH(6)) u_msync (
    .clk_in (mclk_in),
    .d_in   ({uvlo_in, overload_detect_in, thermal_shutdown_in, tone_data_in,
              wr_tog_reg, snap_ack_reg}),
    .q_out  (m_sync)
  );

  scs_sync #(.WIDTH(7)) u_lsync (
    .clk_in (link_clk_in),
    .d_in   ({scl_in, sda_in, silence_reg, snap_req_reg, addr_select_in, reset_in}),
    .q_out  (l_sync)
  );

  assign {uvlo_s, ovl_s, therm_s, tone_s, wr_tog_s, snap_ack_s} = m_sync;
  assign {scl_s, sda_s, silence_s, snap_req_s, addr_sel_s, rst_l_s} = l_sync;

  // System domain decode of control bits.
  wire       pwr_en     = ctrl_reg[BIT_POWER_EN - 2];
  wire       pulsed     = ~ctrl_reg[BIT_PULSED_LIMIT - 2];
  wire       wr_event   = wr_tog_s ^ wr_seen_reg;
  wire       stage_on   = pwr_en & ~otf_reg & (prot_reg != PROT_OFF);
  wire [7:0] reg_value  = {ctrl_reg, otf_reg, olf_reg};
  wire [TIMER_W-1:0] off_last = TIMER_W'(OFF_CYCLES - 1);
  wire [TIMER_W-1:0] on_last  = TIMER_W'(ON_CYCLES - 1);

  // Writes update only the six writable bits; lockout holds them at zero.
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (uvlo_s)
      ctrl_next = CTRL_RESET;
    else if (wr_event)
      ctrl_next = wr_data_reg;
  end

  // Pulsed protection: shut the output off, then retry for a tenth as long.
  always_comb
  begin
    prot_next    = prot_reg;
    timer_next   = timer_reg;
    ov_seen_next = ov_seen_reg;
    case (prot_reg)
      PROT_NORMAL:
      begin
        timer_next = '0;
        if (pulsed && pwr_en && ovl_s)
          prot_next = PROT_OFF;
      end
      PROT_OFF:
      begin
        timer_next = timer_reg + 1'b1;
        if (timer_reg == off_last)
        begin
          prot_next    = PROT_RETRY;
          timer_next   = '0;
          ov_seen_next = 1'b0;
        end
      end
      PROT_RETRY:
      begin
        timer_next   = timer_reg + 1'b1;
        ov_seen_next = ov_seen_reg | ovl_s;
        if (timer_reg == on_last)
        begin
          timer_next = '0;
          prot_next  = (ov_seen_reg | ovl_s) ? PROT_OFF : PROT_NORMAL;
        end
      end
      default:
      begin
        prot_next = PROT_NORMAL;
      end
    endcase
    // Leaving pulsed mode or standby abandons the cycle at once.
    if (!pulsed || !pwr_en)
      prot_next = PROT_NORMAL;
  end

  // Overload flag is timer driven in pulsed mode and live in static mode.
  always_comb
  begin
    if (!pwr_en)
      olf_next = 1'b0;
    else if (pulsed)
      olf_next = (prot_next != PROT_NORMAL);
    else
      olf_next = ovl_s;
  end

  // Register state in the system domain.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      ctrl_reg    <= CTRL_RESET;
      wr_seen_reg <= 1'b0;
      silence_reg <= 1'b1;
      otf_reg     <= 1'b0;
      olf_reg     <= 1'b0;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      wr_seen_reg <= wr_tog_s;
      silence_reg <= uvlo_s;
      otf_reg     <= therm_s & ~uvlo_s;
      olf_reg     <= olf_next & ~uvlo_s;
    end
  end

  // Protection timer; the long counts are parameters so benches can shorten them.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      prot_reg    <= PROT_NORMAL;
      timer_reg   <= '0;
      ov_seen_reg <= 1'b0;
    end
    else
    begin
      prot_reg    <= prot_next;
      timer_reg   <= timer_next;
      ov_seen_reg <= ov_seen_next;
    end
  end

  // Snapshot handshake: a new copy is launched only after the last one was taken.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      snap_reg     <= REG_RESET;
      snap_req_reg <= 1'b0;
    end
    else if (snap_ack_s == snap_req_reg)
    begin
      snap_reg     <= reg_value;
      snap_req_reg <= ~snap_req_reg;
    end
  end

  // Power stage outputs, gated by power enable and the protections; the static clamp by power enable and the pulsed limit bit only.
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      power_stage_on_out      <= 1'b0;
      high_voltage_select_out <= 1'b0;
      cable_loss_comp_out     <= 1'b0;
      tone_gate_out           <= 1'b0;
      rx_output_on_out        <= 1'b0;
      tx_output_on_out        <= 1'b0;
      static_clamp_out        <= 1'b0;
    end
    else
    begin
      power_stage_on_out      <= stage_on;
      high_voltage_select_out <= stage_on & ctrl_reg[BIT_HV_SEL - 2];
      cable_loss_comp_out     <= stage_on & ctrl_reg[BIT_LOSS_COMP - 2];
      tone_gate_out           <= stage_on & (ctrl_reg[BIT_TONE_EN - 2] | tone_s);
      rx_output_on_out        <= stage_on & ~ctrl_reg[BIT_TX_SEL - 2];
      tx_output_on_out        <= stage_on & ctrl_reg[BIT_TX_SEL - 2];
      static_clamp_out        <= pwr_en & ~pulsed;
    end
  end

  // Link domain reset follows system reset and undervoltage lockout.
  wire       l_rst    = silence_s;
  wire       scl_f    = filt_reg[0];
  wire       sda_f    = filt_reg[1];
  wire       scl_rise = scl_f & ~scl_d_reg;
  wire       scl_fall = ~scl_f & scl_d_reg;
  wire       start_ev = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  wire       stop_ev  = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
  wire [6:0] my_addr  = ADDR_BASE + {5'h00, addr_sel_s};
  wire       byte_end = (cnt_reg == BYTE_BITS);
  wire [1:0] bus_raw  = {sda_s, scl_s};

  // A change is accepted only after several equal samples, so spikes are ignored.
  genvar g;
  for (g = 0; g < 2; g++)
  begin : g_filt
    always_ff @(posedge link_clk_in)
    begin
      if (l_rst)
      begin
        filt_reg[g]     <= 1'b1;
        filt_cnt_reg[g] <= 2'h0;
      end
      else if (bus_raw[g] == filt_reg[g])
        filt_cnt_reg[g] <= 2'h0;
      else if (filt_cnt_reg[g] == 2'(FILT_SAMP - 1))
      begin
        filt_reg[g]     <= bus_raw[g];
        filt_cnt_reg[g] <= 2'h0;
      end
      else
        filt_cnt_reg[g] <= filt_cnt_reg[g] + 2'h1;
    end
  end

  // Bus engine: sample on SCL rising, change SDA on SCL falling.
  always_comb
  begin
    bus_next      = bus_reg;
    cnt_next      = cnt_reg;
    shift_next    = shift_reg;
    tx_next       = tx_reg;
    oe_next       = oe_reg;
    rw_next       = rw_reg;
    ack_seen_next = ack_seen_reg;
    wr_tog_next   = wr_tog_reg;
    wr_data_next  = wr_data_reg;
    if (start_ev)
    begin
      bus_next = BUS_ADDR;
      cnt_next = 4'h0;
      oe_next  = 1'b0;
    end
    else if (stop_ev)
    begin
      bus_next = BUS_IDLE;
      oe_next  = 1'b0;
    end
    else if (scl_rise)
    begin
      if (bus_reg == BUS_ADDR || bus_reg == BUS_WRITE)
      begin
        shift_next = {shift_reg[6:0], sda_f};
        cnt_next   = cnt_reg + 4'h1;
      end
      else if (bus_reg == BUS_READ)
        cnt_next = cnt_reg + 4'h1;
      else if (bus_reg == BUS_READ_ACK)
        ack_seen_next = ~sda_f;
    end
    else if (scl_fall)
    begin
      case (bus_reg)
        BUS_ADDR:
        begin
          if (byte_end && shift_reg[7:1] == my_addr)
          begin
            bus_next = BUS_ADDR_ACK;
            oe_next  = 1'b1;
            rw_next  = shift_reg[0];
          end
          else if (byte_end)
            bus_next = BUS_IDLE;
        end
        BUS_ADDR_ACK:
        begin
          cnt_next = 4'h0;
          tx_next  = rd_copy_reg;
          oe_next  = rw_reg & ~rd_copy_reg[7];
          bus_next = rw_reg ? BUS_READ : BUS_WRITE;
        end
        BUS_WRITE:
        begin
          if (byte_end)
          begin
            wr_data_next = shift_reg[7:2];
            wr_tog_next  = ~wr_tog_reg;
            oe_next      = 1'b1;
            bus_next     = BUS_WRITE_ACK;
          end
        end
        BUS_WRITE_ACK:
        begin
          oe_next  = 1'b0;
          cnt_next = 4'h0;
          bus_next = BUS_WRITE;
        end
        BUS_READ:
        begin
          if (byte_end)
          begin
            oe_next  = 1'b0;
            bus_next = BUS_READ_ACK;
          end
          else
          begin
            tx_next = {tx_reg[6:0], 1'b1};
            oe_next = ~tx_reg[6];
          end
        end
        BUS_READ_ACK:
        begin
          cnt_next = 4'h0;
          tx_next  = rd_copy_reg;
          oe_next  = ack_seen_reg & ~rd_copy_reg[7];
          bus_next = ack_seen_reg ? BUS_READ : BUS_IDLE;
        end
        default:
        begin
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // Bus engine registers.
  always_ff @(posedge link_clk_in)
  begin
    if (l_rst)
    begin
      bus_reg      <= BUS_IDLE;
      cnt_reg      <= 4'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      oe_reg       <= 1'b0;
      rw_reg       <= 1'b0;
      ack_seen_reg <= 1'b0;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end
    else
    begin
      bus_reg      <= bus_next;
      cnt_reg      <= cnt_next;
      shift_reg    <= shift_next;
      tx_reg       <= tx_next;
      oe_reg       <= oe_next;
      rw_reg       <= rw_next;
      ack_seen_reg <= ack_seen_next;
      scl_d_reg    <= scl_f;
      sda_d_reg    <= sda_f;
    end
  end

  // Crossing state keeps its value through lockout so toggles stay paired.
  // Write data is held for a whole byte time, far longer than the crossing.
  // System reset reaches this domain only through the link synchroniser.
  always_ff @(posedge link_clk_in)
  begin
    if (rst_l_s)
    begin
      wr_tog_reg   <= 1'b0;
      wr_data_reg  <= CTRL_RESET;
      rd_copy_reg  <= REG_RESET;
      snap_ack_reg <= 1'b0;
      sda_drv_reg  <= 1'b0;
    end
    else
    begin
      wr_tog_reg   <= wr_tog_next;
      wr_data_reg  <= wr_data_next;
      snap_ack_reg <= snap_req_s;
      sda_drv_reg  <= 1'b0;
      if (snap_req_s != snap_ack_reg)
        rd_copy_reg <= snap_reg;
    end
  end

  // The line is only ever pulled low; the data output stays zero.
  assign sda_out_out = sda_drv_reg;
  assign sda_oe_out  = oe_reg;

endmodule

// ### sim/scs_monitor.sv
// Concurrent checks on the ports of the supply control slave.
// Assumes it is bound into scs_top; bus checks run on the link clock.
module scs_monitor (
  // Clocks and reset.
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic link_clk_in,
  // Bus and status inputs.
  input wire logic scl_in,
  input wire logic uvlo_in,
  input wire logic overload_detect_in,
  input wire logic thermal_shutdown_in,
  // Watched outputs.
  input wire logic sda_oe_out,
  input wire logic power_stage_on_out,
  input wire logic high_voltage_select_out,
  input wire logic cable_loss_comp_out,
  input wire logic tone_gate_out,
  input wire logic rx_output_on_out,
  input wire logic tx_output_on_out,
  input wire logic static_clamp_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Output stage checks on the system clock; windows allow for the input synchronisers.
  uvlo_quiet_a:
    assert property (@(posedge mclk_in) disable iff (reset_in)
      uvlo_in [*8] |-> !power_stage_on_out && !static_clamp_out)
    else $error("power stage active during lockout");
  level_gated_a:
    assert property (@(posedge mclk_in) disable iff (reset_in)
      high_voltage_select_out || cable_loss_comp_out
      |-> power_stage_on_out || $past(power_stage_on_out)) else $error("level bit without power");
  one_output_a:
    assert property (@(posedge mclk_in) disable iff (reset_in)
      power_stage_on_out && $past(power_stage_on_out)
      |-> rx_output_on_out ^ tx_output_on_out) else $error("receive and transmit not exclusive");
  stage_off_a:
    assert property (@(posedge mclk_in) disable iff (reset_in)
      !power_stage_on_out && !$past(power_stage_on_out)
      |-> !rx_output_on_out && !tx_output_on_out && !tone_gate_out)
    else $error("output active with stage off");
  thermal_off_a:
    assert property (@(posedge mclk_in) disable iff (reset_in)
      thermal_shutdown_in [*6] |-> !power_stage_on_out)
    else $error("stage on while too hot");
  pulsed_off_a:
    assert property (@(posedge mclk_in) disable iff (reset_in)
      $fell(power_stage_on_out) && !static_clamp_out && overload_detect_in
      |=> !power_stage_on_out [*8]) else $error("pulsed off period too short");
  static_hold_a:
    assert property (@(posedge mclk_in) disable iff (reset_in)
      (static_clamp_out && !thermal_shutdown_in && !uvlo_in) [*8]
      |-> power_stage_on_out) else $error("static clamp turned stage off");
  // The slave may only move SDA while SCL is low, so it stands through SCL high.
  sda_stands_a:
    assert property (@(posedge link_clk_in) disable iff (reset_in)
      $changed(sda_oe_out) && !uvlo_in |-> !scl_in) else $error("SDA moved while SCL high");
  uvlo_silent_a:
    assert property (@(posedge link_clk_in) disable iff (reset_in)
      uvlo_in [*8] |-> !sda_oe_out) else $error("bus answered during lockout");

  // Main scenarios reached.
  cover property (@(posedge link_clk_in) $rose(sda_oe_out));
  cover property (@(posedge mclk_in) disable iff (reset_in)
    $fell(power_stage_on_out) && overload_detect_in);
  cover property (@(posedge mclk_in) disable iff (reset_in)
    static_clamp_out && overload_detect_in && power_stage_on_out);
endmodule

bind scs_top scs_monitor scs_monitor_inst (
  .mclk_in(mclk_in), .reset_in(reset_in), .link_clk_in(link_clk_in), .scl_in(scl_in),
  .uvlo_in(uvlo_in), .overload_detect_in(overload_detect_in),
  .thermal_shutdown_in(thermal_shutdown_in), .sda_oe_out(sda_oe_out),
  .power_stage_on_out(power_stage_on_out), .high_voltage_select_out(high_voltage_select_out),
  .cable_loss_comp_out(cable_loss_comp_out), .tone_gate_out(tone_gate_out),
  .rx_output_on_out(rx_output_on_out), .tx_output_on_out(tx_output_on_out),
  .static_clamp_out(static_clamp_out)
);

// ### sim/scs_host.sv
// Behavioural two-wire bus master standing in for the host controller.
// Assumes the bench resolves SDA as open drain with a pull-up.
module scs_host (
  // Timing clock.
  input  wire logic clk_in,
  // Bus lines.
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // A quarter bit of 13 clocks keeps both SCL phases far above the slave filter.
  localparam int Q = 13;

  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // SDA falls while SCL is high.
  task automatic start();
    sda_oe_out <= 1'b0;
    scl_out <= 1'b1;
    wt(2 * Q);
    sda_oe_out <= 1'b1;
    wt(Q);
    scl_out <= 1'b0;
    wt(Q);
  endtask

  // SDA rises while SCL is high; always sent before the next start.
  task automatic stop();
    sda_oe_out <= 1'b1;
    wt(Q);
    scl_out <= 1'b1;
    wt(Q);
    sda_oe_out <= 1'b0;
    wt(2 * Q);
  endtask

  // Eight bits MSB first, then the acknowledge slot; a one releases SDA.
  // The slot is only recorded, never acted on, as a careless host would.
  task automatic xfer(input logic [8:0] drv, output logic [8:0] seen);
    for (int i = 8; i >= 0; i--)
    begin
      sda_oe_out <= ~drv[i];
      wt(Q);
      scl_out <= 1'b1;
      wt(Q);
      seen[i] = sda_in;
      wt(Q);
      scl_out <= 1'b0;
      wt(Q);
    end
  endtask
endmodule

// ### sim/scs_top_tb.sv
// Self-checking bench for the supply control slave with a host model.
// Assumes short protection counts of 200 and 20 clocks.
module scs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, lclk, uvlo, ovl, therm, tone;
  logic [1:0]  asel;
  logic        host_scl, host_oe, dut_oe, dut_out;
  logic        st, hv, lc, tg, rx, tx, sc;
  logic [8:0]  seen;
  logic [31:0] seed;
  int          errors, comparisons;
  // The pull-up wins unless someone pulls low.
  wire         sda = !(host_oe || (dut_oe && !dut_out));
  wire [6:0]   outs = {st, hv, lc, tg, rx, tx, sc};

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Link clock is offset and has a 32 ns period against 20 ns, so its edges drift against the system clock.
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #16 lclk = ~lclk;
  end

  scs_host scs_host_inst (.clk_in(mclk), .sda_in(sda), .scl_out(host_scl),
    .sda_oe_out(host_oe));
  scs_top #(.OFF_CYCLES(200), .ON_CYCLES(20)) scs_top_inst (
    .mclk_in(mclk), .reset_in(rst), .link_clk_in(lclk), .scl_in(host_scl), .sda_in(sda),
    .sda_out_out(dut_out), .sda_oe_out(dut_oe), .addr_select_in(asel), .uvlo_in(uvlo),
    .overload_detect_in(ovl), .thermal_shutdown_in(therm), .tone_data_in(tone),
    .power_stage_on_out(st), .high_voltage_select_out(hv), .cable_loss_comp_out(lc),
    .tone_gate_out(tg), .rx_output_on_out(rx), .tx_output_on_out(tx),
    .static_clamp_out(sc));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Stage outputs for a control byte when no fault is present.
  function automatic logic [6:0] exp_outs(input logic [7:0] d, input logic t);
    logic s;
    s = d[2];
    return {s, s & d[3], s & d[4], s & (d[5] | t), s & ~d[6], s & d[6], s & d[7]};
  endfunction

  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One write transaction; without an address acknowledge the host gives up.
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic ack);
    scs_host_inst.start();
    scs_host_inst.xfer({a, 2'b01}, seen);
    compare({7'h0, seen[0]}, {7'h0, ~ack});
    if (seen[0] === 1'b0)
    begin
      scs_host_inst.xfer({d, 1'b1}, seen);
      compare({7'h0, seen[0]}, 8'h00);
    end
    scs_host_inst.stop();
    repeat (100) @(posedge mclk);
  endtask

  // Two read bytes: the first acknowledged by the host, the second refused.
  task automatic rd(input logic [7:0] exp);
    logic [8:0] b;
    scs_host_inst.start();
    scs_host_inst.xfer({7'h08, 2'b11}, seen);
    compare({7'h0, seen[0]}, 8'h00);
    scs_host_inst.xfer(9'h1fe, b);
    compare(b[8:1], exp);
    scs_host_inst.xfer(9'h1ff, b);
    compare(b[8:1], exp);
    scs_host_inst.stop();
    repeat (20) @(posedge mclk);
  endtask

  initial
  begin
    logic [7:0] d;
    int n;
    rst = 1'b1;
    {uvlo, ovl, therm, tone, asel} = 6'h00;
    errors = 0;
    comparisons = 0;
    seed = 32'he7b5;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (100) @(posedge mclk);
    compare({1'b0, outs}, 8'h00);
    rd(8'h00);
    // Each strap answers only its own address.
    for (int s = 0; s < 4; s++)
    begin
      asel <= s[1:0];
      repeat (40) @(posedge mclk);
      wr(7'h08, 8'h00, s == 0);
      wr({5'h02, s[1:0]}, 8'h00, 1'b1);
    end
    asel <= 2'h0;
    // Random control bytes with both corner values first.
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      d = (i == 0) ? 8'hff : ((i == 1) ? 8'h03 : seed[7:0]);
      tone <= seed[8];
      wr(7'h08, d, 1'b1);
      compare({1'b0, outs}, {1'b0, exp_outs(d, seed[8])});
      rd({d[7:2], 2'b00});
    end
    wr(7'h08, 8'h2c, 1'b1);
    therm <= 1'b1;
    repeat (20) @(posedge mclk);
    compare({1'b0, outs}, 8'h00);
    rd(8'h2e);
    therm <= 1'b0;
    repeat (20) @(posedge mclk);
    compare({1'b0, outs}, {1'b0, exp_outs(8'h2c, tone)});
    // Transmit output selected together with the tone enable, checked once.
    wr(7'h08, 8'h64, 1'b1);
    compare({1'b0, outs}, {1'b0, exp_outs(8'h64, tone)});
    // Pulsed limiting: off while overloaded, back on after a clean retry.
    wr(7'h08, 8'h04, 1'b1);
    ovl <= 1'b1;
    repeat (10) @(posedge mclk);
    compare({7'h0, st}, 8'h00);
    rd(8'h05);
    ovl <= 1'b0;
    n = 0;
    while (st !== 1'b1 && n < 400)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 400)
    begin
      errors++;
      $display("unexpected at %0t: stage never came back", $time);
      conclude();
    end
    compare({7'h0, st}, 8'h01);
    repeat (60) @(posedge mclk);
    rd(8'h04);
    // Static clamping keeps the stage on and flags the overload live.
    wr(7'h08, 8'h84, 1'b1);
    ovl <= 1'b1;
    repeat (20) @(posedge mclk);
    compare({7'h0, st}, 8'h01);
    rd(8'h85);
    ovl <= 1'b0;
    repeat (20) @(posedge mclk);
    rd(8'h84);
    // Lockout silences the bus and clears the register.
    uvlo <= 1'b1;
    repeat (20) @(posedge mclk);
    compare({1'b0, outs}, 8'h00);
    wr(7'h08, 8'h04, 1'b0);
    uvlo <= 1'b0;
    repeat (100) @(posedge mclk);
    rd(8'h00);
    conclude();
  end
endmodule
